// file: hw/inlf_front.sv
// input trim, normalisation, peak hold, input select and lock-in front end
//------------------------------------------------------------
//------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "inlf_defs.svh"
module inlf_front (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire inlf_pkg::inlf_quad_type raw_sample_in,
  input wire logic sample_valid_in,
  input wire inlf_pkg::inlf_pair_type regulator_out_in,
  input wire logic [`INLF_ADDR_W-1:0] reg_addr_in,
  input wire logic [`INLF_DATA_W-1:0] reg_wr_data_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [`INLF_DATA_W-1:0] reg_rd_data_out,
  output inlf_pkg::inlf_pair_type norm_out,
  output inlf_pkg::inlf_pair_type filter_i_out,
  output inlf_pkg::inlf_pair_type filter_q_out,
  output inlf_pkg::inlf_pair_type dither_out,
  output logic out_valid_out,
  output logic [1:0] trigger_status_out,
  output logic [1:0] loop_freeze_out
);
  parameter logic [`INLF_TIMER_W-1:0] TIMEOUT_RESET = `INLF_TIMEOUT_RESET;

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  localparam logic [16:0][15:0] SIN_TAB = {
    16'h7FFF, 16'h7F62, 16'h7D89, 16'h7A7C, 16'h7641, 16'h70E2, 16'h6A6D, 16'h62F1, 16'h5A82,
    16'h5133, 16'h471C, 16'h3C56, 16'h30FB, 16'h2528, 16'h18F9, 16'h0C8C, 16'h0000};
  // response shaping weight in sixteenths; bessel has no peaking, chebyshev the most
  localparam logic [5:0][4:0] PEAK_TAB = {5'h09, 5'h08, 5'h07, 5'h06, 5'h04, 5'h00};

  function automatic inlf_pkg::inlf_sample_type sat16(input logic signed [63:0] v);
    if (v > 64'sh7FFF) begin
      return 16'sh7FFF;
    end else if (v < -64'sh8000) begin
      return -16'sh8000;
    end
    return v[15:0];
  endfunction

  function automatic logic signed [31:0] q15(input logic signed [31:0] x, input inlf_pkg::inlf_sample_type w);
    logic signed [47:0] p;
    p = x * w;
    return 32'(p >>> `INLF_Q15_SHIFT);
  endfunction

  // quarter-wave table, 64 points per turn; coarse but cheap
  function automatic inlf_pkg::inlf_sample_type sine(input logic [`INLF_PHASE_W-1:0] ph);
    logic [4:0] idx;
    logic signed [15:0] mag;
    // top bit picks the half turn, the next one mirrors the quarter, four bits index the table
    idx = ph[`INLF_PHASE_W-2] ? 5'(16 - ph[`INLF_PHASE_W-3-:4]) : {1'b0, ph[`INLF_PHASE_W-3-:4]};
    if (ph[`INLF_PHASE_W-2] && ph[`INLF_PHASE_W-3-:4] == 4'h0) begin
      idx = 5'h10;
    end
    mag = SIN_TAB[idx];
    return ph[`INLF_PHASE_W-1] ? -mag : mag;
  endfunction

  function automatic logic [3:0] follow_shift(input logic [`INLF_PHASE_W-1:0] inc);
    logic [4:0] msb;
    logic [5:0] k;
    msb = 5'h0;
    for (int i = 0; i < `INLF_PHASE_W; i++) begin
      if (inc[i]) begin
        msb = 5'(i);
      end
    end
    // alpha of a one-pole at a third of the dither rate is about inc / 2^23
    k = {1'b0, `INLF_FOLLOW_BASE} - {1'b0, msb};
    return (k > {2'b00, `INLF_MAX_SHIFT}) ? `INLF_MAX_SHIFT : k[3:0];
  endfunction

  function automatic inlf_pkg::inlf_state_type reset_state();
    inlf_pkg::inlf_state_type r;
    r = '0;
    r.cfg[0].ctrl.simple_norm_enable = 1'b1;
    r.cfg[1].ctrl.simple_norm_enable = 1'b1;
    r.cfg[0].ctrl.input_select = 2'h1;
    r.cfg[1].ctrl.input_select = 2'h1;
    r.pulse_valid_timeout = TIMEOUT_RESET;
    for (int c = 0; c < 2; c++) begin
      r.ch[c].sh_state = inlf_pkg::INLF_SH_IDLE;
      r.ch[c].trig_ok = 1'b1;
    end
    return r;
  endfunction

  localparam inlf_pkg::inlf_state_type RESET_STATE = reset_state();

  inlf_pkg::inlf_state_type s_q;
  inlf_pkg::inlf_state_type s_d;

  //------------------------------------------------------------
  // next state
  //------------------------------------------------------------
  always_comb begin
    logic signed [31:0] acc;
    logic signed [31:0] num;
    logic signed [31:0] den;
    logic signed [31:0] wp;
    logic signed [31:0] ws;
    logic signed [63:0] q;
    logic signed [31:0] diff;
    logic [`INLF_PHASE_W-1:0] hph;
    logic [3:0] k;
    inlf_pkg::inlf_sample_type bal;
    inlf_pkg::inlf_sample_type x;
    inlf_pkg::inlf_sample_type x2;
    inlf_pkg::inlf_quad_type v;
    inlf_pkg::inlf_pair_type mix;
    inlf_pkg::inlf_ctrl_type ct;
    logic [`INLF_PHASE_W-1:0] ph_next [2];
    s_d = s_q;
    acc = '0;
    num = '0;
    den = '0;
    wp = '0;
    ws = '0;
    q = '0;
    diff = '0;
    hph = '0;
    k = '0;
    bal = '0;
    x = '0;
    x2 = '0;
    v = s_q.avg;
    mix = '0;
    ct = '0;
    ph_next[0] = s_q.ch[0].phase;
    ph_next[1] = s_q.ch[1].phase;
    s_d.valid_pipe = {s_q.valid_pipe[1:0], sample_valid_in};

    // register writes
    if (reg_wr_in) begin
      if ({reg_addr_in[5:2], 2'b00} == `INLF_REG_OFFSET_BASE) begin
        s_d.raw_offset_trim[reg_addr_in[1:0]] = reg_wr_data_in[15:0];
      end
      if (reg_addr_in == `INLF_REG_AVG_DEPTH) begin
        s_d.raw_average_depth = reg_wr_data_in[7:0];
      end
      if (reg_addr_in == `INLF_REG_TIMEOUT) begin
        s_d.pulse_valid_timeout = reg_wr_data_in[`INLF_TIMER_W-1:0];
      end
      for (int c = 0; c < 2; c++) begin
        if (reg_addr_in[5:4] == (c == 0 ? `INLF_CH_SEL_A : `INLF_CH_SEL_B)) begin
          unique case (reg_addr_in[3:0]) inside
            `INLF_CH_CTRL: s_d.cfg[c].ctrl = reg_wr_data_in[$bits(inlf_pkg::inlf_ctrl_type)-1:0];
            `INLF_CH_BALANCE: begin
              bal = reg_wr_data_in[15:0];
              // balance is clamped to plus or minus 0.8 in q15
              if (bal > `INLF_BAL_LIMIT) begin
                bal = `INLF_BAL_LIMIT;
              end else if (bal < -`INLF_BAL_LIMIT) begin
                bal = -`INLF_BAL_LIMIT;
              end
              s_d.cfg[c].balance_weight = bal;
            end
            [`INLF_CH_NUM_W0:`INLF_CH_DEN_W0-4'h1]:
              s_d.cfg[c].expert_numerator_weight[2'(reg_addr_in[3:0] - `INLF_CH_NUM_W0)] = reg_wr_data_in[15:0];
            [`INLF_CH_DEN_W0:`INLF_CH_DEN_W4]:
              s_d.cfg[c].expert_denominator_weight[3'(reg_addr_in[3:0] - `INLF_CH_DEN_W0)] = reg_wr_data_in[15:0];
            `INLF_CH_UPPER: s_d.cfg[c].peak_upper_threshold = reg_wr_data_in[15:0];
            `INLF_CH_LOWER: s_d.cfg[c].peak_lower_threshold = reg_wr_data_in[15:0];
            `INLF_CH_AMP: s_d.cfg[c].dither_amplitude = reg_wr_data_in[15:0];
            `INLF_CH_FREQ: s_d.cfg[c].dither_freq = reg_wr_data_in[`INLF_PHASE_W-1:0];
            `INLF_CH_MODE2: s_d.cfg[c].mode2 = reg_wr_data_in[$bits(inlf_pkg::inlf_mode2_type)-1:0];
            default: ;
          endcase
        end
      end
    end

    // register reads: data stands only in the cycle after the strobe
    s_d.rd_data = '0;
    if (reg_rd_in) begin
      if (reg_addr_in == `INLF_REG_STATUS) begin
        s_d.rd_data = {28'h0, s_q.ch[1].sh_state == inlf_pkg::INLF_SH_TRACK,
                       s_q.ch[0].sh_state == inlf_pkg::INLF_SH_TRACK, s_q.ch[1].trig_ok, s_q.ch[0].trig_ok};
      end else if (reg_addr_in == `INLF_REG_NORM) begin
        s_d.rd_data = {s_q.ch[1].norm, s_q.ch[0].norm};
      end else if ({reg_addr_in[5:2], 2'b00} == `INLF_REG_OFFSET_BASE) begin
        s_d.rd_data = 32'(unsigned'(s_q.raw_offset_trim[reg_addr_in[1:0]]));
      end
    end

    // trigger timeout runs on every clock so the timeout is in clock cycles
    for (int c = 0; c < 2; c++) begin
      if (s_q.ch[c].sh_timer != {`INLF_TIMER_W{1'b1}}) begin
        s_d.ch[c].sh_timer = s_q.ch[c].sh_timer + 1'b1;
      end
      s_d.ch[c].trig_ok = !s_q.cfg[c].ctrl.sh_enable || (s_q.ch[c].sh_timer < s_q.pulse_valid_timeout);
    end

    if (sample_valid_in) begin
      // stage 1: trim and history
      s_d.hist[`INLF_HIST_DEPTH-1:1] = s_q.hist[`INLF_HIST_DEPTH-2:0];
      for (int i = 0; i < 4; i++) begin
        s_d.hist[0][i] = sat16(64'(raw_sample_in[i]) + 64'(s_q.raw_offset_trim[i]));
        acc = '0;
        for (int j = 0; j < `INLF_HIST_DEPTH; j++) begin
          if (j < (1 << s_q.raw_average_depth[i])) begin
            acc = acc + 32'(s_q.hist[j][i]);
          end
        end
        s_d.avg[i] = acc[15:0];
        s_d.avg[i] = 16'(acc >>> s_q.raw_average_depth[i]);
      end

      for (int c = 0; c < 2; c++) begin
        ct = s_q.cfg[c].ctrl;
        // the pulse flag stands until the next sample, where the phase step consumes it
        s_d.ch[c].pulse = 1'b0;
        // stage 2: normalisation
        if (ct.simple_norm_enable) begin
          bal = s_q.cfg[c].balance_weight;
          wp = 32'(v[c == 0 ? 0 : 2]);
          ws = 32'(v[c == 0 ? 1 : 3]);
          wp = wp + q15(wp, bal);
          ws = ws - q15(ws, bal);
          unique case (ct.numerator_select)
            2'h0: num = 32'(v[c]);
            2'h1: num = -32'(v[c]);
            default: num = wp - ws;
          endcase
          unique case (ct.denominator_select)
            2'h0: den = '0;
            2'h1: den = 32'(v[c == 0 ? 1 : 2]);
            2'h2: den = 32'(v[c == 0 ? 0 : 2]) + 32'(v[c == 0 ? 1 : 3]);
            default: den = 32'(v[c == 0 ? 2 : 3]);
          endcase
        end else begin
          num = '0;
          den = 32'(s_q.cfg[c].expert_denominator_weight[0]);
          for (int i = 0; i < 4; i++) begin
            num = num + q15(32'(v[i]), s_q.cfg[c].expert_numerator_weight[i]);
            den = den + q15(32'(v[i]), s_q.cfg[c].expert_denominator_weight[i+1]);
          end
        end
        if (ct.simple_norm_enable && ct.denominator_select == 2'h0) begin
          q = 64'(num) <<< s_q.cfg[c].mode2.division_binary_gain;
        end else if (den == 0) begin
          q = (num < 0) ? -64'sh8000 : 64'sh7FFF;
        end else begin
          q = (64'(num) <<< (`INLF_Q15_SHIFT + s_q.cfg[c].mode2.division_binary_gain)) / 64'(den);
        end
        s_d.ch[c].norm = sat16(q);

        // stage 3: pulsed peak hold
        x = s_q.ch[c].norm;
        if (x > s_q.cfg[c].peak_upper_threshold || x < s_q.cfg[c].peak_lower_threshold) begin
          s_d.ch[c].sh_timer = '0;
        end
        unique case (s_q.ch[c].sh_state)
          inlf_pkg::INLF_SH_IDLE: begin
            if (x > s_q.cfg[c].peak_upper_threshold) begin
              s_d.ch[c].sh_state = inlf_pkg::INLF_SH_TRACK;
              s_d.ch[c].peak = x;
            end
          end
          inlf_pkg::INLF_SH_TRACK: begin
            if (x > s_q.ch[c].peak) begin
              s_d.ch[c].peak = x;
            end
            if (x < s_q.cfg[c].peak_lower_threshold) begin
              s_d.ch[c].held = s_q.ch[c].peak;
              s_d.ch[c].pulse = 1'b1;
              s_d.ch[c].sh_state = inlf_pkg::INLF_SH_IDLE;
            end
          end
        endcase
        x = ct.sh_enable ? s_q.ch[c].held : s_q.ch[c].norm;

        // stage 4: input select
        unique case (ct.input_select)
          2'h0: s_d.ch[c].selected = s_q.avg[ct.raw_index];
          2'h1: s_d.ch[c].selected = x;
          default: s_d.ch[c].selected = regulator_out_in[c == 0 ? 1 : 0];
        endcase

        // stage 5: dither and mixers
        ph_next[c] = s_q.ch[c].phase + s_q.cfg[c].dither_freq;
        if (ct.dither_pulse_sync && s_q.ch[c].pulse) begin
          ph_next[c] = ph_next[c] + `INLF_QUARTER_TURN;
        end
        hph = 24'(s_q.ch[c].phase * ct.demod_harmonic_select);
        x = s_q.ch[c].selected;
        x2 = ct.mix2_indep ? s_q.avg[3] : x;
        if (ct.demod_harmonic_select == 2'h0) begin
          mix[0] = x;
          mix[1] = x2;
        end else begin
          mix[0] = sat16(64'(q15(32'(x), sine(hph))));
          mix[1] = sat16(64'(q15(32'(x2), sine(hph + `INLF_QUARTER_TURN))));
        end
        s_d.ch[c].dither = sat16(64'(q15(32'(s_q.cfg[c].dither_amplitude), sine(s_q.ch[c].phase))));

        // stage 6: low-pass, updated once per divided sample
        s_d.ch[c].div_cnt = s_q.ch[c].div_cnt + 1'b1;
        if (s_q.ch[c].div_cnt >= s_q.cfg[c].mode2.filter_rate_divider) begin
          s_d.ch[c].div_cnt = '0;
          k = ct.cutoff_follow_dither ? follow_shift(s_q.cfg[c].dither_freq) : s_q.cfg[c].mode2.lowpass_cutoff;
          for (int m = 0; m < 2; m++) begin
            diff = (32'(mix[m]) - 32'(s_q.ch[c].lp1[m])) >>> k;
            s_d.ch[c].lp1[m] = sat16(64'(s_q.ch[c].lp1[m]) + 64'(diff));
            diff = (32'(s_q.ch[c].lp1[m]) - 32'(s_q.ch[c].lp2[m])) >>> k;
            diff = diff + ((diff * $signed(32'(PEAK_TAB[ct.lowpass_response_type > 3'h5 ? 3'h5
                          : ct.lowpass_response_type]))) >>> `INLF_PEAK_SHIFT);
            s_d.ch[c].lp2[m] = sat16(64'(s_q.ch[c].lp2[m]) + 64'(diff));
          end
        end
      end
      s_d.ch[0].phase = ph_next[0];
      // equal frequency settings share one phase so both dithers stay in step
      s_d.ch[1].phase = (s_q.cfg[0].dither_freq == s_q.cfg[1].dither_freq) ? ph_next[0] : ph_next[1];
    end
  end

  //------------------------------------------------------------
  // state register
  //------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  always_comb begin
    reg_rd_data_out = s_q.rd_data;
    out_valid_out = s_q.valid_pipe[0];
    for (int c = 0; c < 2; c++) begin
      norm_out[c] = s_q.ch[c].norm;
      filter_i_out[c] = s_q.ch[c].lp2[0];
      filter_q_out[c] = s_q.ch[c].lp2[1];
      dither_out[c] = s_q.ch[c].dither;
      trigger_status_out[c] = s_q.ch[c].trig_ok;
      loop_freeze_out[c] = !s_q.ch[c].trig_ok;
    end
  end
endmodule // inlf_front
`default_nettype wire

// file: shared/inlf_defs.svh
// constants for the input normalise and lock-in front end
`ifndef INLF_DEFS_SVH
`define INLF_DEFS_SVH
`define INLF_SAMPLE_W 16
`define INLF_ADDR_W 6
`define INLF_DATA_W 32
`define INLF_PHASE_W 24
`define INLF_TIMER_W 20
`define INLF_HIST_DEPTH 8
// register word addresses
`define INLF_REG_OFFSET_BASE 6'h00
`define INLF_REG_AVG_DEPTH 6'h04
`define INLF_REG_TIMEOUT 6'h05
`define INLF_REG_STATUS 6'h06
`define INLF_REG_NORM 6'h07
`define INLF_CH_SEL_A 2'h1
`define INLF_CH_SEL_B 2'h2
// word indexes inside a channel block
`define INLF_CH_CTRL 4'h0
`define INLF_CH_BALANCE 4'h1
`define INLF_CH_NUM_W0 4'h2
`define INLF_CH_DEN_W0 4'h6
`define INLF_CH_DEN_W4 4'hA
`define INLF_CH_UPPER 4'hB
`define INLF_CH_LOWER 4'hC
`define INLF_CH_AMP 4'hD
`define INLF_CH_FREQ 4'hE
`define INLF_CH_MODE2 4'hF
// numeric limits and fixed values
`define INLF_BAL_LIMIT 16'sh6666
`define INLF_Q15_SHIFT 15
`define INLF_QUARTER_TURN 24'h400000
`define INLF_FOLLOW_BASE 5'h17
`define INLF_MAX_SHIFT 4'hF
`define INLF_PEAK_SHIFT 4
`define INLF_TIMEOUT_RESET 20'h186A0
`endif

// file: shared/inlf_pkg.sv
// types of the input normalise and lock-in front end
`include "inlf_defs.svh"
package inlf_pkg;
  typedef logic signed [`INLF_SAMPLE_W-1:0] inlf_sample_type;
  typedef inlf_sample_type [3:0] inlf_quad_type;
  typedef inlf_sample_type [1:0] inlf_pair_type;
  typedef enum logic [1:0] {INLF_SH_IDLE = 2'b01, INLF_SH_TRACK = 2'b10} inlf_sh_state_type;
  typedef enum logic [2:0] {
    INLF_RESP_BESSEL, INLF_RESP_BUTTER, INLF_RESP_CHEB05, INLF_RESP_CHEB10, INLF_RESP_CHEB20, INLF_RESP_CHEB30
  } inlf_resp_type;
  // control word layout, lsb last
  typedef struct packed {
    logic mix2_indep;
    logic dither_pulse_sync;
    logic cutoff_follow_dither;
    logic [2:0] lowpass_response_type;
    logic [1:0] demod_harmonic_select;
    logic [1:0] raw_index;
    logic [1:0] input_select;
    logic sh_enable;
    logic simple_norm_enable;
    logic [1:0] denominator_select;
    logic [1:0] numerator_select;
  } inlf_ctrl_type;
  typedef struct packed {
    logic [7:0] filter_rate_divider;
    logic [3:0] lowpass_cutoff;
    logic [3:0] division_binary_gain;
  } inlf_mode2_type;
  typedef struct packed {
    inlf_ctrl_type ctrl;
    inlf_mode2_type mode2;
    inlf_sample_type balance_weight;
    inlf_sample_type [3:0] expert_numerator_weight;
    inlf_sample_type [4:0] expert_denominator_weight;
    inlf_sample_type peak_upper_threshold;
    inlf_sample_type peak_lower_threshold;
    inlf_sample_type dither_amplitude;
    logic [`INLF_PHASE_W-1:0] dither_freq;
  } inlf_chan_cfg_type;
  typedef struct packed {
    inlf_sh_state_type sh_state;
    inlf_sample_type peak;
    inlf_sample_type held;
    logic [`INLF_TIMER_W-1:0] sh_timer;
    logic trig_ok;
    logic pulse;
    inlf_sample_type norm;
    inlf_sample_type selected;
    logic [`INLF_PHASE_W-1:0] phase;
    logic [7:0] div_cnt;
    inlf_pair_type lp1;
    inlf_pair_type lp2;
    inlf_sample_type dither;
  } inlf_chan_state_type;
  typedef struct packed {
    inlf_chan_cfg_type [1:0] cfg;
    inlf_quad_type raw_offset_trim;
    logic [3:0][1:0] raw_average_depth;
    logic [`INLF_TIMER_W-1:0] pulse_valid_timeout;
    inlf_quad_type [`INLF_HIST_DEPTH-1:0] hist;
    inlf_quad_type avg;
    inlf_chan_state_type [1:0] ch;
    logic [2:0] valid_pipe;
    logic [`INLF_DATA_W-1:0] rd_data;
  } inlf_state_type;
endpackage : inlf_pkg

// file: verification/inlf_front_sva.sv
// port assertions for the input normalise and lock-in front end
`timescale 1ns/10ps
`default_nettype none
`include "inlf_defs.svh"
module inlf_front_sva #(
  parameter logic [`INLF_TIMER_W-1:0] TIMEOUT_RESET = `INLF_TIMEOUT_RESET
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic sample_valid_in,
  input wire logic [`INLF_ADDR_W-1:0] reg_addr_in,
  input wire logic [`INLF_DATA_W-1:0] reg_wr_data_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [`INLF_DATA_W-1:0] reg_rd_data_out,
  input wire inlf_pkg::inlf_pair_type norm_out,
  input wire inlf_pkg::inlf_pair_type filter_i_out,
  input wire logic out_valid_out,
  input wire logic [1:0] trigger_status_out,
  input wire logic [1:0] loop_freeze_out
);
  wire [15:0] wr_low = reg_wr_data_in[15:0];
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence wr_trim_a;
    reg_wr_in && reg_addr_in == `INLF_REG_OFFSET_BASE;
  endsequence
  sequence rd_trim_a;
    reg_rd_in && reg_addr_in == `INLF_REG_OFFSET_BASE;
  endsequence
  a_valid_follows: assert property (sample_valid_in |=> out_valid_out)
    else $error("output strobe missing after a sample");
  a_valid_caused: assert property (out_valid_out |-> $past(sample_valid_in))
    else $error("output strobe without a sample");
  a_freeze_inverse: assert property (loop_freeze_out == ~trigger_status_out)
    else $error("freeze is not the inverse of trigger status");
  a_read_idle_zero: assert property (!reg_rd_in |=> reg_rd_data_out == '0)
    else $error("read data not zero outside a read answer");
  a_unmapped_read: assert property (reg_rd_in && reg_addr_in == 6'h08 |=> reg_rd_data_out == '0)
    else $error("unmapped read not zero");
  a_hold_between: assert property (!sample_valid_in |=> $stable(norm_out) && $stable(filter_i_out))
    else $error("data output moved without a sample");
  a_trim_readback: assert property (wr_trim_a ##1 rd_trim_a |=> reg_rd_data_out[15:0] == $past(wr_low, 2))
    else $error("trim readback differs from write");
  a_status_read: assert property (reg_rd_in && reg_addr_in == `INLF_REG_STATUS |=>
    reg_rd_data_out[1:0] == $past(trigger_status_out))
    else $error("status word disagrees with trigger status");
  a_norm_read: assert property (reg_rd_in && reg_addr_in == `INLF_REG_NORM |=>
    reg_rd_data_out == $past(norm_out))
    else $error("norm word disagrees with norm output");
endmodule // inlf_front_sva
bind inlf_front inlf_front_sva #(.TIMEOUT_RESET(TIMEOUT_RESET)) u_sva (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .sample_valid_in(sample_valid_in), .reg_addr_in(reg_addr_in), .reg_wr_data_in(reg_wr_data_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rd_data_out(reg_rd_data_out), .norm_out(norm_out),
  .filter_i_out(filter_i_out), .out_valid_out(out_valid_out), .trigger_status_out(trigger_status_out),
  .loop_freeze_out(loop_freeze_out));
`default_nettype wire

// file: verification/inlf_adc_model.sv
// converter model: four raw samples with a one-cycle strobe at a settable spacing
`timescale 1ns/10ps
`default_nettype none
module inlf_adc_model (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [7:0] spacing_in,
  input wire inlf_pkg::inlf_quad_type level_in,
  output inlf_pkg::inlf_quad_type raw_sample_out,
  output logic sample_valid_out
);
  logic [7:0] gap_q;
  inlf_pkg::inlf_quad_type last_q;
  // off the strobe the bus shows the inverse, so a late sampler picks up garbage
  assign raw_sample_out = sample_valid_out ? last_q : ~last_q;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap_q <= 8'h00;
      sample_valid_out <= 1'b0;
      last_q <= '0;
    end else begin
      sample_valid_out <= (gap_q == 8'h00);
      gap_q <= (gap_q == 8'h00) ? spacing_in - 8'h01 : gap_q - 8'h01;
      if (gap_q == 8'h00) last_q <= level_in;
    end
  end
endmodule // inlf_adc_model
`default_nettype wire

// file: verification/input_normalize_lockin_front_tb_top.sv
// testbench for the input normalise and lock-in front end
`timescale 1ns/10ps
`default_nettype none
module input_normalize_lockin_front_tb_top;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] spacing = 8'h08;
  inlf_pkg::inlf_quad_type lvl = '0;
  inlf_pkg::inlf_quad_type raw;
  inlf_pkg::inlf_pair_type reg_out = '0;
  inlf_pkg::inlf_pair_type norm;
  inlf_pkg::inlf_pair_type fi;
  inlf_pkg::inlf_pair_type fq;
  inlf_pkg::inlf_pair_type dith;
  logic valid;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic ov;
  logic [1:0] trig;
  logic [1:0] frz;
  logic [15:0] pulse [5] = '{16'h1000, 16'h5000, 16'h6000, 16'h1000, 16'h3000};
  int failures = 0;
  int checks_done = 0;
  always #5 clock_in = ~clock_in;
  inlf_adc_model adc (.clock_in(clock_in), .rst_n_in(rst_n_in), .spacing_in(spacing), .level_in(lvl),
    .raw_sample_out(raw), .sample_valid_out(valid));
  inlf_front #(.TIMEOUT_RESET(20'h32)) DUT (.clock_in(clock_in), .rst_n_in(rst_n_in), .raw_sample_in(raw),
    .sample_valid_in(valid), .regulator_out_in(reg_out), .reg_addr_in(addr), .reg_wr_data_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rd_data_out(rdata), .norm_out(norm), .filter_i_out(fi),
    .filter_q_out(fq), .dither_out(dith), .out_valid_out(ov), .trigger_status_out(trig), .loop_freeze_out(frz));
  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // leading edge keeps two writes from touching the strobe in one step
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp, input string msg);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    #1;
    check(rdata, exp, msg);
    @(posedge clock_in);
  endtask
  task automatic samples(input int n);
    int got;
    int lim;
    got = 0;
    lim = 0;
    while (got < n && lim < 5000) begin
      @(posedge clock_in);
      #1;
      if (ov === 1'b1) got++;
      lim++;
    end
    if (got < n) begin
      failures++;
      $display("MISMATCH %0t no output strobe", $time);
      conclude();
    end else begin
      // two more edges let level outputs derived from the last sample settle
      repeat (2) @(posedge clock_in);
    end
  endtask
  //------------------------------------------------------------
  // scenarios
  //------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock_in);
    check({30'h0, trig}, 32'h3, "reset trigger");
    check(norm, 32'h0, "reset norm");
    rst_n_in <= 1'b1;
    lvl[0] <= 16'h1000;
    wr_reg(6'h00, 32'h100);
    rd_chk(6'h00, 32'h100, "trim readback");
    samples(6);
    check(norm, 32'h1100, "trimmed a");
    rd_chk(6'h07, 32'h1100, "norm word");
    rd_chk(6'h08, 32'h0, "unmapped");
    wr_reg(6'h10, 32'h51);
    samples(6);
    check({16'h0, norm[0]}, 32'hEF00, "negated a");
    lvl[1] <= 16'h0400;
    wr_reg(6'h10, 32'h52);
    wr_reg(6'h11, 32'h4000);
    samples(6);
    check({16'h0, norm[0]}, 32'h1780, "balanced difference");
    wr_reg(6'h11, 32'h7FFF);
    samples(6);
    check({16'h0, norm[0]}, 32'h1DCC, "balance limit");
    lvl[1] <= 16'h1100;
    wr_reg(6'h10, 32'h58);
    wr_reg(6'h1F, 32'h1);
    samples(6);
    check({16'h0, norm[0]}, 32'h7FFF, "saturated ratio");
    wr_reg(6'h1F, 32'h0);
    wr_reg(6'h10, 32'h40);
    wr_reg(6'h12, 32'h4000);
    wr_reg(6'h16, 32'h2200);
    samples(6);
    check({16'h0, norm[0]}, 32'h2000, "expert ratio");
    wr_reg(6'h10, 32'h50);
    wr_reg(6'h04, 32'h1);
    for (int i = 0; i < 10; i++) begin
      lvl[0] <= i[0] ? 16'h3000 : 16'h1000;
      samples(1);
    end
    check({16'h0, norm[0]}, 32'h2100, "average of two");
    wr_reg(6'h04, 32'h0);
    wr_reg(6'h00, 32'h0);
    wr_reg(6'h1B, 32'h4000);
    wr_reg(6'h1C, 32'h2000);
    wr_reg(6'h10, 32'h70);
    foreach (pulse[i]) begin
      lvl[0] <= pulse[i];
      samples(1);
    end
    samples(14);
    check({16'h0, fi[0]}, 32'h6000, "held peak");
    check({30'h0, trig[0], frz[0]}, 32'h1, "trigger lost");
    lvl[0] <= 16'h1000;
    samples(4);
    check({31'h0, trig[0]}, 32'h1, "trigger back");
    spacing <= 8'h28;
    reg_out <= {16'h1234, 16'h1234};
    wr_reg(6'h10, 32'h90);
    samples(6);
    check({16'h0, fi[0]}, 32'h1234, "regulator path");
    wr_reg(6'h10, 32'h110);
    samples(6);
    check({16'h0, fi[0]}, 32'h1100, "raw b path");
    wr_reg(6'h06, 32'h0);
    rd_chk(6'h06, 32'hB, "status word");
    wr_reg(6'h1D, 32'h7FFF);
    wr_reg(6'h20, 32'h51);
    wr_reg(6'h10, 32'h10510);
    lvl[0] <= 16'h5000;
    samples(4);
    lvl[0] <= 16'h1000;
    samples(10);
    check({16'h0, dith[0]}, 32'h7FFE, "dither after pulse");
    check({fq[0], fi[0]}, 32'h10FF, "quadrature mix");
    check({16'h0, norm[1]}, 32'hEF00, "negated b");
    conclude();
  end
endmodule // input_normalize_lockin_front_tb_top
`default_nettype wire
